// file: pkg/charge_warn_pkg.sv
`default_nettype none
package charge_warn_pkg;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CAPACITY = 8'h00;
  localparam logic [7:0] ADDR_INIT_SET = 8'h04;
  localparam logic [7:0] ADDR_INIT_CLR = 8'h08;
  localparam logic [7:0] ADDR_FINAL_SET = 8'h0c;
  localparam logic [7:0] ADDR_FINAL_CLR = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h24;
  localparam logic [7:0] ADDR_CAP_LOAD = 8'h28;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int FLAG_INIT_BIT = 0;
  localparam int FLAG_FINAL_BIT = 1;
  localparam int IRQ_INIT_SET = 0;
  localparam int IRQ_INIT_CLR = 1;
  localparam int IRQ_FINAL_SET = 2;
  localparam int IRQ_FINAL_CLR = 3;
  localparam logic signed [15:0] FINAL_DISABLED = -16'sd1;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic signed [15:0] RST_CAPACITY = 16'sh03e8;
  localparam logic signed [15:0] RST_INIT_SET = 16'sh0096;
  localparam logic signed [15:0] RST_INIT_CLR = 16'sh00af;
  localparam logic signed [15:0] RST_FINAL_SET = 16'sh004b;
  localparam logic signed [15:0] RST_FINAL_CLR = 16'sh0064;
  localparam logic [15:0] CHIP_ID = 16'h5a5a; // arbitrary value
  // charge accumulator: sense samples summed until one mAh of charge
  localparam logic signed [31:0] CHARGE_PER_MAH = 32'sh0000_0e10;
  localparam int EVAL_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EVAL_CYCLES = EVAL_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic signed [15:0] capacity;
    logic signed [31:0] charge_acc;
    logic [9:0] eval_cnt;
    logic signed [15:0] init_set;
    logic signed [15:0] init_clr;
    logic signed [15:0] final_set;
    logic signed [15:0] final_clr;
    logic charge_low_initial_flag;
    logic charge_low_final_flag;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic irq;
    logic [31:0] rdata;
  } state_s;
endpackage : charge_warn_pkg
`default_nettype wire

// file: logic/charge_warn.sv
`default_nettype none
module charge_warn (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // sense sample, signed (pos minus neg), one per cycle when valid
  input wire logic i_sense_valid,
  input wire logic signed [15:0] i_sense_sample,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // status
  output logic o_charge_low_initial_flag,
  output logic o_charge_low_final_flag,
  output logic o_irq
);

  charge_warn_pkg::state_s q;
  charge_warn_pkg::state_s d;
  logic eval;
  logic signed [31:0] acc_sum;
  logic [3:0] irq_event;
  logic [3:0] irq_clear;
  logic irq_clr_wr;
  logic cap_load;
  logic final_enabled;
  logic init_set_hit;
  logic init_clr_hit;
  logic final_set_hit;
  logic final_clr_hit;

  function automatic logic [31:0] sext16(input logic signed [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  // strict compares: sitting exactly on a level never moves a flag
  function automatic logic below(input logic signed [15:0] v, input logic signed [15:0] lvl);
    below = v < lvl;
  endfunction : below

  function automatic logic above(input logic signed [15:0] v, input logic signed [15:0] lvl);
    above = v > lvl;
  endfunction : above

  function automatic logic is_wr(input logic wr, input logic [7:0] a, input logic [7:0] target);
    is_wr = wr && (a == target);
  endfunction : is_wr

  // ----------------------------------------
  // threshold and write decode
  // ----------------------------------------
  assign final_enabled = (q.final_set != charge_warn_pkg::FINAL_DISABLED);
  assign init_set_hit = !q.charge_low_initial_flag && below(q.capacity, q.init_set);
  assign init_clr_hit = q.charge_low_initial_flag && above(q.capacity, q.init_clr);
  assign final_set_hit = !q.charge_low_final_flag && final_enabled && below(q.capacity, q.final_set);
  assign final_clr_hit = q.charge_low_final_flag && above(q.capacity, q.final_clr);
  assign cap_load = is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_CAP_LOAD);
  assign irq_clr_wr = is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_IRQ_CLEAR);
  assign irq_clear = irq_clr_wr ? i_wdata[3:0] : 4'h0;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.rdata = 32'h0;
    eval = 1'b0;
    irq_event = 4'h0;
    acc_sum = q.charge_acc + 32'(i_sense_sample);
    // charge integration
    if (i_sense_valid) begin
      d.charge_acc = acc_sum;
      if (acc_sum >= charge_warn_pkg::CHARGE_PER_MAH) begin
        d.charge_acc = acc_sum - charge_warn_pkg::CHARGE_PER_MAH;
        d.capacity = q.capacity + 16'sd1;
      end else if (acc_sum <= -charge_warn_pkg::CHARGE_PER_MAH) begin
        d.charge_acc = acc_sum + charge_warn_pkg::CHARGE_PER_MAH;
        d.capacity = q.capacity - 16'sd1;
      end
    end
    // periodic recompute of the warning flags
    if (q.eval_cnt == 10'(charge_warn_pkg::EVAL_CYCLES - 1)) begin
      d.eval_cnt = 10'h0;
      eval = 1'b1;
    end else begin
      d.eval_cnt = q.eval_cnt + 10'h1;
    end
    // flags only move at eval; hysteresis keeps them steady otherwise
    if (eval) begin
      if (!q.charge_low_initial_flag && q.capacity < q.init_set) begin
        d.charge_low_initial_flag = 1'b1;
        irq_event[charge_warn_pkg::IRQ_INIT_SET] = 1'b1;
      end else if (q.charge_low_initial_flag && q.capacity > q.init_clr) begin
        d.charge_low_initial_flag = 1'b0;
        irq_event[charge_warn_pkg::IRQ_INIT_CLR] = 1'b1;
      end
      if (!q.charge_low_final_flag && q.capacity < q.final_set
          && q.final_set != charge_warn_pkg::FINAL_DISABLED) begin
        d.charge_low_final_flag = 1'b1;
        irq_event[charge_warn_pkg::IRQ_FINAL_SET] = 1'b1;
      end else if (q.charge_low_final_flag && q.capacity > q.final_clr) begin
        d.charge_low_final_flag = 1'b0;
        irq_event[charge_warn_pkg::IRQ_FINAL_CLR] = 1'b1;
      end
    end
    // register writes; clear loses to a same-cycle event
    if (i_wr) begin
      unique case (i_addr)
        charge_warn_pkg::ADDR_INIT_SET: d.init_set = i_wdata[15:0];
        charge_warn_pkg::ADDR_INIT_CLR: d.init_clr = i_wdata[15:0];
        charge_warn_pkg::ADDR_FINAL_SET: d.final_set = i_wdata[15:0];
        charge_warn_pkg::ADDR_FINAL_CLR: d.final_clr = i_wdata[15:0];
        charge_warn_pkg::ADDR_IRQ_ENABLE: d.irq_enable = i_wdata[3:0];
        charge_warn_pkg::ADDR_CAP_LOAD: begin
          d.capacity = i_wdata[15:0];
          d.charge_acc = 32'sh0;
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        charge_warn_pkg::ADDR_CAPACITY: d.rdata = sext16(q.capacity);
        charge_warn_pkg::ADDR_INIT_SET: d.rdata = sext16(q.init_set);
        charge_warn_pkg::ADDR_INIT_CLR: d.rdata = sext16(q.init_clr);
        charge_warn_pkg::ADDR_FINAL_SET: d.rdata = sext16(q.final_set);
        charge_warn_pkg::ADDR_FINAL_CLR: d.rdata = sext16(q.final_clr);
        charge_warn_pkg::ADDR_FLAGS: begin
          d.rdata[charge_warn_pkg::FLAG_INIT_BIT] = q.charge_low_initial_flag;
          d.rdata[charge_warn_pkg::FLAG_FINAL_BIT] = q.charge_low_final_flag;
        end
        charge_warn_pkg::ADDR_IRQ_STATUS: d.rdata = {28'h0, q.irq_status};
        charge_warn_pkg::ADDR_IRQ_ENABLE: d.rdata = {28'h0, q.irq_enable};
        charge_warn_pkg::ADDR_CHIP_ID: d.rdata = {16'h0, charge_warn_pkg::CHIP_ID};
        default: d.rdata = 32'h0;
      endcase
    end
    // sticky status: an event in the clear cycle survives the clear
    d.irq_status = (q.irq_status & ~irq_clear) | irq_event;
    d.irq = |(d.irq_status & d.irq_enable);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.capacity <= charge_warn_pkg::RST_CAPACITY;
      q.init_set <= charge_warn_pkg::RST_INIT_SET;
      q.init_clr <= charge_warn_pkg::RST_INIT_CLR;
      q.final_set <= charge_warn_pkg::RST_FINAL_SET;
      q.final_clr <= charge_warn_pkg::RST_FINAL_CLR;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_charge_low_initial_flag = q.charge_low_initial_flag;
  assign o_charge_low_final_flag = q.charge_low_final_flag;
  assign o_irq = q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_init_sets: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && !q.charge_low_initial_flag && q.capacity < q.init_set |=> o_charge_low_initial_flag)
    else $error("initial flag did not set");
  a_init_clears: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && q.charge_low_initial_flag && q.capacity > q.init_clr |=> !o_charge_low_initial_flag)
    else $error("initial flag did not clear");
  a_final_sets: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && !q.charge_low_final_flag && q.capacity < q.final_set && q.final_set != -16'sd1
    |=> o_charge_low_final_flag)
    else $error("final flag did not set");
  a_final_disabled: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(o_charge_low_final_flag) |-> $past(q.final_set) != charge_warn_pkg::FINAL_DISABLED)
    else $error("final flag set while disabled");
  a_final_clears: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $fell(o_charge_low_final_flag) |-> $past(q.capacity > q.final_clr))
    else $error("final flag cleared without cause");
  a_flags_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !eval |=> $stable(o_charge_low_initial_flag) && $stable(o_charge_low_final_flag))
    else $error("flag moved between evaluations");
  a_flag_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == charge_warn_pkg::ADDR_FLAGS
    |=> o_rdata[1:0] == {$past(q.charge_low_final_flag), $past(q.charge_low_initial_flag)})
    else $error("flag word wrong");
  a_charge_up: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_sense_valid && !cap_load && acc_sum >= 32'sh0e10 |=> q.capacity == $past(q.capacity) + 16'sd1)
    else $error("capacity not incremented");

  // ----------------------------------------
  // checks: warning flags and events
  // ----------------------------------------
  a_init_set_irq: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && init_set_hit |=> q.irq_status[charge_warn_pkg::IRQ_INIT_SET])
    else $error("initial set event missing");

  a_init_clr_irq: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && init_clr_hit |=> q.irq_status[charge_warn_pkg::IRQ_INIT_CLR])
    else $error("initial clear event missing");

  a_final_set_irq: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && final_set_hit |=> q.irq_status[charge_warn_pkg::IRQ_FINAL_SET])
    else $error("final set event missing");

  a_final_clr_irq: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && final_clr_hit |=> q.irq_status[charge_warn_pkg::IRQ_FINAL_CLR])
    else $error("final clear event missing");

  a_init_band_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && q.charge_low_initial_flag && !(q.capacity > q.init_clr) |=> o_charge_low_initial_flag)
    else $error("initial flag cleared inside band");

  a_init_no_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && !q.charge_low_initial_flag && !(q.capacity < q.init_set) |=> !o_charge_low_initial_flag)
    else $error("initial flag set above level");

  a_final_band_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && q.charge_low_final_flag && !(q.capacity > q.final_clr) |=> o_charge_low_final_flag)
    else $error("final flag cleared inside band");

  a_final_no_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && !q.charge_low_final_flag && !(q.capacity < q.final_set) |=> !o_charge_low_final_flag)
    else $error("final flag set above level");

  a_final_off_holds: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && !q.charge_low_final_flag && q.final_set == charge_warn_pkg::FINAL_DISABLED |=> !o_charge_low_final_flag)
    else $error("disabled final flag set");

  a_init_sets_cause: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(o_charge_low_initial_flag) |-> $past(q.capacity < q.init_set))
    else $error("initial flag set without cause");

  a_init_clears_cause: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $fell(o_charge_low_initial_flag) |-> $past(q.capacity > q.init_clr))
    else $error("initial flag cleared without cause");

  a_final_sets_cause: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(o_charge_low_final_flag) |-> $past(q.capacity < q.final_set))
    else $error("final flag set without cause");

  a_eval_spacing: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval |=> !eval [*8])
    else $error("evaluation ticks too close");

  a_eval_count: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    q.eval_cnt <= 10'(charge_warn_pkg::EVAL_CYCLES - 1))
    else $error("evaluation counter out of range");

  // ----------------------------------------
  // checks: charge integration
  // ----------------------------------------
  a_charge_down: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_sense_valid && !cap_load && acc_sum <= -32'sh0e10 |=> q.capacity == $past(q.capacity) - 16'sd1)
    else $error("capacity not decremented");

  a_cap_load: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cap_load |=> q.capacity == $past(i_wdata[15:0]))
    else $error("capacity load lost");

  a_acc_cleared: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    cap_load |=> q.charge_acc == 32'sh0)
    else $error("accumulator not cleared on load");

  a_cap_steady: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_sense_valid && !cap_load |=> $stable(q.capacity))
    else $error("capacity moved without charge");

  a_capacity_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == charge_warn_pkg::ADDR_CAPACITY |=> o_rdata[15:0] == $past(q.capacity))
    else $error("capacity read wrong");

  // ----------------------------------------
  // checks: register port and interrupt
  // ----------------------------------------
  a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_rd |=> o_rdata == 32'h0)
    else $error("read data outside its cycle");

  a_chip_id_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == charge_warn_pkg::ADDR_CHIP_ID |=> o_rdata[15:0] == charge_warn_pkg::CHIP_ID)
    else $error("id read wrong");

  a_status_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == charge_warn_pkg::ADDR_IRQ_STATUS |=> o_rdata[3:0] == $past(q.irq_status))
    else $error("status read wrong");

  a_enable_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_rd && i_addr == charge_warn_pkg::ADDR_IRQ_ENABLE |=> o_rdata[3:0] == $past(q.irq_enable))
    else $error("enable read wrong");

  a_init_set_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_INIT_SET) |=> q.init_set == $past(i_wdata[15:0]))
    else $error("initial set level write lost");

  a_init_clr_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_INIT_CLR) |=> q.init_clr == $past(i_wdata[15:0]))
    else $error("initial clear level write lost");

  a_final_set_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_FINAL_SET) |=> q.final_set == $past(i_wdata[15:0]))
    else $error("final set level write lost");

  a_final_clr_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_FINAL_CLR) |=> q.final_clr == $past(i_wdata[15:0]))
    else $error("final clear level write lost");

  a_enable_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    is_wr(i_wr, i_addr, charge_warn_pkg::ADDR_IRQ_ENABLE) |=> q.irq_enable == $past(i_wdata[3:0]))
    else $error("enable write lost");

  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_irq == |(q.irq_status & q.irq_enable))
    else $error("interrupt level wrong");

  a_status_sticky: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !irq_clr_wr |=> (q.irq_status & $past(q.irq_status)) == $past(q.irq_status))
    else $error("status bit fell without clear");

  a_irq_clear_works: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    irq_clr_wr && !eval |=> (q.irq_status & $past(i_wdata[3:0])) == 4'h0)
    else $error("status clear ignored");

  a_set_beats_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    eval && init_set_hit && irq_clr_wr |=> q.irq_status[charge_warn_pkg::IRQ_INIT_SET])
    else $error("clear swallowed a same-cycle event");

endmodule : charge_warn
`default_nettype wire

// file: dv/charge_warn_host.sv
`default_nettype none
// ----------------------------------------
// host model on the register port
// ----------------------------------------
module charge_warn_host (
  // clock
  input wire logic i_ref_clk,
  // register port
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_addr = 8'hff;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    // idle bus shows no stale value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    // read data stands only in this cycle
    #1 d = i_rdata;
  endtask : rd
endmodule : charge_warn_host
`default_nettype wire

// file: dv/charge_warn_test.sv
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module charge_warn_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, vld, f_i, f_f, irq, fi, ff;
  logic signed [15:0] smp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic wr, rd;
  int errors, checked, cap, si, sc, fs, fc;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24, 8'h2c};
  logic [31:0] rv [7] = '{32'h3e8, 32'h96, 32'haf, 32'h4b, 32'h64, 32'h5a5a, 32'h0};
  charge_warn charge_warn_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_sense_valid(vld), .i_sense_sample(smp),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_charge_low_initial_flag(f_i), .o_charge_low_final_flag(f_f), .o_irq(irq));
  charge_warn_host h (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // ----------------------------------------
  // reference model and helpers
  // ----------------------------------------
  function automatic void eval_model();
    if (cap < si) fi = 1'b1;
    else if (cap > sc) fi = 1'b0;
    if (fs != -1 && cap < fs) ff = 1'b1;
    else if (ff && cap > fc) ff = 1'b0;
  endfunction : eval_model
  // idle with noise on the sample while it is marked invalid
  task automatic idle(int n);
    repeat (n) @(posedge clk) smp <= 16'($urandom);
  endtask : idle
  // two evaluations at most; a steady capacity gives the same result
  task automatic load(int c);
    h.wr(charge_warn_pkg::ADDR_CAP_LOAD, 32'(c));
    cap = c;
    idle(260);
    eval_model();
  endtask : load
  task automatic check_flags();
    h.rd(charge_warn_pkg::ADDR_FLAGS, d);
    `CHK("flags", {30'h0, ff, fi}, d)
    `CHK("initial", fi, f_i)
    `CHK("final", ff, f_f)
  endtask : check_flags
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    smp = 16'sh0;
    {cap, si, sc, fs, fc, fi, ff} = {32'd1000, 32'd150, 32'd175, 32'd75, 32'd100, 2'b00};
    void'($urandom(41431));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    h.wr(charge_warn_pkg::ADDR_CAPACITY, 32'h5);
    for (int k = 0; k < 7; k++) begin
      h.rd(ra[k], d);
      `CHK("reset value", rv[k], d)
    end
    h.wr(charge_warn_pkg::ADDR_IRQ_ENABLE, 32'h1);
    load(140);
    h.rd(charge_warn_pkg::ADDR_IRQ_STATUS, d);
    `CHK("irq status", 32'h1, d)
    `CHK("irq", 1'b1, irq)
    h.wr(charge_warn_pkg::ADDR_IRQ_CLEAR, 32'hf);
    load(70);
    h.rd(charge_warn_pkg::ADDR_IRQ_STATUS, d);
    `CHK("irq masked status", 32'h4, d)
    `CHK("irq masked", 1'b0, irq)
    check_flags();
    repeat (16) begin
      load($urandom_range(0, 220));
      check_flags();
    end
    load(200);
    h.wr(charge_warn_pkg::ADDR_FINAL_SET, 32'hffffffff);
    fs = -1;
    load(10);
    check_flags();
    load(-3);
    check_flags();
    load(100);
    repeat (7) @(posedge clk) {vld, smp} <= {1'b1, 16'sd1200};
    @(posedge clk) vld <= 1'b0;
    idle(260);
    cap = 102;
    h.rd(charge_warn_pkg::ADDR_CAPACITY, d);
    `CHK("capacity", 32'd102, d)
    repeat (7) @(posedge clk) {vld, smp} <= {1'b1, 16'shfb50};
    @(posedge clk) vld <= 1'b0;
    h.rd(charge_warn_pkg::ADDR_CAPACITY, d);
    `CHK("capacity down", 32'd100, d)
    summarize();
  end
endmodule : charge_warn_test
`default_nettype wire
